// ===== dac_core_pkg.sv
package dac_core_pkg;

    // ----------------------------------------------------------------
    // Register map (serial configuration addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_SKEW = 15'h007F;
    localparam logic [ADDR_W-1:0] ADDR_DUTY_TRIM = 15'h0082;
    localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL_MID = 15'h0083;
    localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL_LAST = 15'h0084;
    localparam logic [ADDR_W-1:0] ADDR_SHUFFLE = 15'h0151;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 15'h0152;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DUTY_CORR_BIT = 7;
    localparam int DUTY_OFFS_EN_BIT = 6;
    localparam int DUTY_SIGN_BIT = 4;
    localparam int SKEW_SIGN_BIT = 5;
    localparam int SHUF_EN_BIT = 2;

    // ----------------------------------------------------------------
    // Serial frame counts
    // ----------------------------------------------------------------
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam int SAMPLE_W = 16;
    localparam int LFSR_W = 16;

    typedef enum logic [1:0] {
        MODE_NRZ = 2'b00,
        MODE_CHOP = 2'b01,
        MODE_ZERO_ON_FALLING = 2'b10,
        MODE_SPARE = 2'b11
    } core_mode_t;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_INSTR = 2'b01,
        SPI_DATA = 2'b10,
        SPI_DONE = 2'b11
    } spi_state_t;

    typedef struct packed {
        logic sclk;
        logic csb_n;
        logic sdi;
    } spi_pins_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] rise;
        logic [SAMPLE_W-1:0] fall;
    } core_drive_t;

    typedef struct packed {
        logic duty_corr_en;
        logic duty_offs_en;
        logic duty_offs_neg;
        logic [3:0] duty_offs_mag;
        logic [4:0] cap_pos;
        logic [4:0] cap_neg;
    } clk_trim_t;

    typedef struct packed {
        spi_pins_t pin_s1;
        spi_pins_t pin_s2;
        logic sclk_d;
        spi_state_t spi_st;
        logic [3:0] bit_cnt;
        logic [15:0] shift;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0] out_sh;
        logic sdo;
        logic sdo_oe;
        logic [7:0] skew_reg;
        logic [7:0] duty_reg;
        logic [7:0] shuf_reg;
        logic [7:0] mode_reg;
        core_drive_t drive;
        clk_trim_t trim;
        logic shuf_en;
        logic [LFSR_W-1:0] lfsr;
    } state_t;

endpackage

// ===== dac_core_mode_and_clock_trim.sv
// How it works
// - Each switch pair updates on one edge only
// - Zero mode: sample rising, zero falling
// - Chop mode: falling gets complemented sample
// - Baseband: same sample on both edges
// - Mode field at 0x152 bits 1:0
// - Doubler feeds new sample each edge in baseband
// - Duty trim 0x082: enables and offset word
// - Duty offset is sign and magnitude
// - Phase skew 0x07F steers capacitance per sign
// - Bit 2 of 0x151 enables shuffling
// - Shuffling touches only MSB segments
// - Clock controls occupy 0x082 through 0x084
`timescale 1ns/1ps
`default_nettype none

module dac_core_mode_and_clock_trim #(
    parameter int SHUF_W = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire dac_core_pkg::spi_pins_t i_spi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    input wire logic [dac_core_pkg::SAMPLE_W-1:0] i_sample_a,
    input wire logic [dac_core_pkg::SAMPLE_W-1:0] i_sample_b,
    input wire logic i_half_band_en,
    output dac_core_pkg::core_drive_t o_drive,
    output dac_core_pkg::clk_trim_t o_clk_trim,
    output logic o_shuffle_en,
    output logic [SHUF_W-1:0] o_shuffle_sel
);
    import dac_core_pkg::*;

    state_t st_r;
    state_t st_nxt;
    logic rst_meta_r;
    logic rst_n_r;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_fire;
    logic [7:0] wdata;
    logic [ADDR_W-1:0] addr_in;
    core_mode_t mode;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Unlisted code maps to baseband
    function automatic core_mode_t decode_mode(input logic [1:0] code);
        case (code)
            2'b01: decode_mode = MODE_CHOP;
            2'b10: decode_mode = MODE_ZERO_ON_FALLING;
            default: decode_mode = MODE_NRZ;
        endcase
    endfunction

    // Magnitude routed to one side by its sign bit
    function automatic logic [4:0] side_mag(input logic neg, input logic want_neg,
                                            input logic [4:0] mag);
        side_mag = (neg == want_neg) ? mag : 5'h00;
    endfunction

    function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a, input state_t s);
        case (a)
            ADDR_PHASE_SKEW: reg_read = s.skew_reg;
            ADDR_DUTY_TRIM: reg_read = s.duty_reg;
            ADDR_CLK_CTRL_MID: reg_read = READ_ZERO;
            ADDR_CLK_CTRL_LAST: reg_read = READ_ZERO;
            ADDR_SHUFFLE: reg_read = s.shuf_reg;
            ADDR_MODE: reg_read = s.mode_reg;
            default: reg_read = READ_ZERO;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = i_spi;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.sclk_d = st_r.pin_s2.sclk;
        sclk_rise = st_r.pin_s2.sclk & ~st_r.sclk_d;
        sclk_fall = ~st_r.pin_s2.sclk & st_r.sclk_d;
        addr_in = {st_r.shift[13:0], st_r.pin_s2.sdi};
        wdata = {st_r.shift[6:0], st_r.pin_s2.sdi};
        wr_fire = 1'b0;

        // Serial slave: 16-bit instruction, then one data byte
        if (st_r.pin_s2.csb_n) begin
            st_nxt.spi_st = SPI_IDLE;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sdo_oe = 1'b0;
            st_nxt.sdo = 1'b0;
        end else begin
            case (st_r.spi_st)
                SPI_IDLE: begin
                    st_nxt.spi_st = SPI_INSTR;
                    st_nxt.bit_cnt = 4'h0;
                end
                SPI_INSTR: begin
                    if (sclk_rise) begin
                        st_nxt.shift = {st_r.shift[14:0], st_r.pin_s2.sdi};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                        if (st_r.bit_cnt == INSTR_LAST) begin
                            st_nxt.rd = st_r.shift[14];
                            st_nxt.addr = addr_in;
                            st_nxt.out_sh = reg_read(addr_in, st_r);
                            st_nxt.bit_cnt = 4'h0;
                            st_nxt.spi_st = SPI_DATA;
                        end
                    end
                end
                SPI_DATA: begin
                    if (sclk_fall && st_r.rd) begin
                        st_nxt.sdo = st_r.out_sh[7];
                        st_nxt.sdo_oe = 1'b1;
                        st_nxt.out_sh = {st_r.out_sh[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        st_nxt.shift = {st_r.shift[14:0], st_r.pin_s2.sdi};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                        if (st_r.bit_cnt == DATA_LAST) begin
                            wr_fire = ~st_r.rd;
                            st_nxt.spi_st = SPI_DONE;
                        end
                    end
                end
                SPI_DONE: begin
                    if (sclk_fall) begin
                        st_nxt.sdo_oe = 1'b0;
                    end
                end
                default: st_nxt.spi_st = SPI_IDLE;
            endcase
        end

        // Register writes; unmapped addresses are ignored
        if (wr_fire) begin
            case (st_r.addr)
                ADDR_PHASE_SKEW: st_nxt.skew_reg = wdata;
                ADDR_DUTY_TRIM: st_nxt.duty_reg = wdata;
                ADDR_SHUFFLE: st_nxt.shuf_reg = wdata;
                ADDR_MODE: st_nxt.mode_reg = wdata;
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Core sample presentation
        // ------------------------------------------------------------
        mode = decode_mode(st_r.mode_reg[1:0]);
        // pair A rising, pair B falling
        st_nxt.drive.rise = i_sample_a;
        case (mode)
            MODE_ZERO_ON_FALLING: st_nxt.drive.fall = '0;
            MODE_CHOP: st_nxt.drive.fall = ~i_sample_a;
            default: begin
                st_nxt.drive.fall = i_half_band_en ? i_sample_b : i_sample_a;
            end
        endcase

        // ------------------------------------------------------------
        // Clock trims
        // ------------------------------------------------------------
        st_nxt.trim.duty_corr_en = st_r.duty_reg[DUTY_CORR_BIT];
        st_nxt.trim.duty_offs_en = st_r.duty_reg[DUTY_OFFS_EN_BIT];
        st_nxt.trim.duty_offs_neg = st_r.duty_reg[DUTY_SIGN_BIT];
        st_nxt.trim.duty_offs_mag = st_r.duty_reg[3:0];
        st_nxt.trim.cap_pos = side_mag(st_r.skew_reg[SKEW_SIGN_BIT], 1'b0, st_r.skew_reg[4:0]);
        st_nxt.trim.cap_neg = side_mag(st_r.skew_reg[SKEW_SIGN_BIT], 1'b1, st_r.skew_reg[4:0]);

        // ------------------------------------------------------------
        // Shuffle selector for the MSB segments
        // ------------------------------------------------------------
        // enable bit
        st_nxt.shuf_en = st_r.shuf_reg[SHUF_EN_BIT];
        if (st_r.shuf_reg[SHUF_EN_BIT]) begin
            st_nxt.lfsr = {st_r.lfsr[LFSR_W-2:0],
                           ~(st_r.lfsr[15] ^ st_r.lfsr[14] ^ st_r.lfsr[12] ^ st_r.lfsr[3])};
        end else begin
            st_nxt.lfsr = '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= '0;
            st_r.pin_s1.csb_n <= 1'b1;
            st_r.pin_s2.csb_n <= 1'b1;
            st_r.skew_reg <= REG_RESET;
            st_r.duty_reg <= REG_RESET;
            st_r.shuf_reg <= REG_RESET;
            st_r.mode_reg <= REG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_spi_sdo = st_r.sdo;
    assign o_spi_sdo_oe = st_r.sdo_oe;
    assign o_drive = st_r.drive;
    assign o_clk_trim = st_r.trim;
    assign o_shuffle_en = st_r.shuf_en;
    assign o_shuffle_sel = st_r.lfsr[SHUF_W-1:0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n_r);

    property p_pair_rise;
        ##1 o_drive.rise == $past(i_sample_a);
    endproperty
    a_pair_rise: assert property (p_pair_rise) else $error("rise pair word wrong");

    property p_zero_fall;
        $past(st_r.mode_reg[1:0]) == 2'b10 |-> o_drive.fall == '0;
    endproperty
    a_zero_fall: assert property (p_zero_fall) else $error("falling word not zero");

    property p_chop_fall;
        $past(st_r.mode_reg[1:0]) == 2'b01 |-> o_drive.fall == ~o_drive.rise;
    endproperty
    a_chop_fall: assert property (p_chop_fall) else $error("falling word not complement");

    property p_nrz_fall;
        $past(st_r.mode_reg[1:0]) == 2'b00 && !$past(i_half_band_en)
            |-> o_drive.fall == o_drive.rise;
    endproperty
    a_nrz_fall: assert property (p_nrz_fall) else $error("baseband words differ");

    property p_mode_write;
        wr_fire && st_r.addr == ADDR_MODE |=> st_r.mode_reg == $past(wdata);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_spare_mode;
        $past(st_r.mode_reg[1:0]) == 2'b11 && !$past(i_half_band_en)
            |-> o_drive.fall == o_drive.rise;
    endproperty
    a_spare_mode: assert property (p_spare_mode) else $error("spare mode not baseband");

    property p_doubler;
        $past(st_r.mode_reg[0]) == $past(st_r.mode_reg[1]) && $past(i_half_band_en)
            |-> o_drive.fall == $past(i_sample_b);
    endproperty
    a_doubler: assert property (p_doubler) else $error("doubler sample missing");

    property p_duty;
        ##1 o_clk_trim.duty_corr_en == $past(st_r.duty_reg[7])
            && o_clk_trim.duty_offs_en == $past(st_r.duty_reg[6])
            && o_clk_trim.duty_offs_neg == $past(st_r.duty_reg[4])
            && o_clk_trim.duty_offs_mag == $past(st_r.duty_reg[3:0]);
    endproperty
    a_duty: assert property (p_duty) else $error("duty trim mismatch");

    property p_skew;
        ##1 ($past(st_r.skew_reg[5]) ? (o_clk_trim.cap_pos == 5'h00
            && o_clk_trim.cap_neg == $past(st_r.skew_reg[4:0]))
            : (o_clk_trim.cap_neg == 5'h00 && o_clk_trim.cap_pos == $past(st_r.skew_reg[4:0])));
    endproperty
    a_skew: assert property (p_skew) else $error("phase skew routing wrong");

    property p_shuffle_off;
        !o_shuffle_en |-> o_shuffle_sel == '0;
    endproperty
    a_shuffle_off: assert property (p_shuffle_off) else $error("shuffle active while off");

    c_zero_mode: cover property ($past(st_r.mode_reg[1:0]) == 2'b10 ##1 o_drive.rise != '0);
    c_chop_mode: cover property ($past(st_r.mode_reg[1:0]) == 2'b01);
    c_read: cover property (o_spi_sdo_oe ##1 o_spi_sdo);
    c_shuffle: cover property (o_shuffle_en && o_shuffle_sel != '0);

endmodule

`default_nettype wire

// ===== config_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Serial configuration host: one byte per frame, clock idle low
// ----------------------------------------------------------------
module config_host_model (
    input wire logic i_clk_sys,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output var dac_core_pkg::spi_pins_t o_spi
);
    import dac_core_pkg::*;

    logic sdo_last = 1'b0;
    logic sdo_line;

    // Released line shows the inverse of its last driven level
    always @(posedge i_clk_sys) begin
        if (i_sdo_oe) begin
            sdo_last <= i_sdo;
        end
    end
    assign sdo_line = i_sdo_oe ? i_sdo : ~sdo_last;

    initial begin
        o_spi = '{sclk: 1'b0, csb_n: 1'b1, sdi: 1'b0};
    end

    // Half period of five system clocks keeps above the sync minimum
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [23:0] w;
        w = {rd, a, d};
        q = 8'h00;
        @(negedge i_clk_sys);
        o_spi.csb_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            o_spi.sdi = w[23 - i];
            repeat (5) @(negedge i_clk_sys);
            o_spi.sclk = 1'b1;
            if (i >= 16) begin
                q[23 - i] = sdo_line;
            end
            repeat (5) @(negedge i_clk_sys);
            o_spi.sclk = 1'b0;
        end
        repeat (5) @(negedge i_clk_sys);
        o_spi.csb_n = 1'b1;
        repeat (10) @(negedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// ===== dac_core_mode_and_clock_trim_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dac_core_mode_and_clock_trim_tb_top;
    import dac_core_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    spi_pins_t spi;
    logic sdo;
    logic sdo_oe;
    logic hb_en = 1'b0;
    logic shuf_en;
    logic [3:0] shuf_sel;
    logic [SAMPLE_W-1:0] s_a = 16'h0000;
    logic [SAMPLE_W-1:0] s_b = 16'h0000;
    core_drive_t drive;
    clk_trim_t trim;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    dac_core_mode_and_clock_trim i_dac_core_mode_and_clock_trim (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_spi(spi),
        .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .i_sample_a(s_a), .i_sample_b(s_b),
        .i_half_band_en(hb_en), .o_drive(drive), .o_clk_trim(trim),
        .o_shuffle_en(shuf_en), .o_shuffle_sel(shuf_sel)
    );
    config_host_model i_config_host_model (
        .i_clk_sys(i_clk_sys), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_spi(spi)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_config_host_model.frame(1'b0, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_config_host_model.frame(1'b1, a, 8'h00, q);
        check(what, 32'(exp), 32'(q));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd_chk("skew", ADDR_PHASE_SKEW, REG_RESET);
        rd_chk("duty", ADDR_DUTY_TRIM, REG_RESET);
        rd_chk("shuffle", ADDR_SHUFFLE, REG_RESET);
        rd_chk("mode", ADDR_MODE, REG_RESET);
        check("trim", 32'h0, 32'(trim));
        check("sel", 32'h0, 32'(shuf_sel));
    endtask

    task automatic t_rw;
        logic [14:0] adr [4] = '{ADDR_PHASE_SKEW, ADDR_DUTY_TRIM, ADDR_SHUFFLE, ADDR_MODE};
        logic [7:0] val [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], val[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk("readback", adr[i], val[i]);
        end
        wr(ADDR_CLK_CTRL_MID, 8'hFF);
        rd_chk("ctrl_mid", ADDR_CLK_CTRL_MID, READ_ZERO);
        rd_chk("ctrl_last", ADDR_CLK_CTRL_LAST, READ_ZERO);
        wr(15'h0100, 8'hFF);
        rd_chk("unmapped", 15'h0100, READ_ZERO);
        rd_chk("mode_kept", ADDR_MODE, 8'h3C);
    endtask

    task automatic t_trims;
        logic [7:0] sk [6] = '{8'h03, 8'h1F, 8'h20, 8'h23, 8'h3F, 8'hC5};
        logic [9:0] cp [6] = '{10'h060, 10'h3E0, 10'h000, 10'h003, 10'h01F, 10'h0A0};
        wr(ADDR_DUTY_TRIM, 8'hF5);
        check("duty", 32'h75, 32'({trim[16:10]}));
        wr(ADDR_DUTY_TRIM, 8'h4A);
        check("duty", 32'h2A, 32'({trim[16:10]}));
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_PHASE_SKEW, sk[i]);
            check("caps", 32'(cp[i]), 32'({trim.cap_pos, trim.cap_neg}));
        end
    endtask

    task automatic t_modes;
        logic [15:0] a;
        logic [15:0] f;
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_MODE, 8'(m));
            for (int k = 0; k < 4; k++) begin
                a = 16'hA5C3 + 16'(k * 16'h1111);
                s_a = a;
                s_b = a ^ 16'h0F0F;
                hb_en = k[0];
                f = (m == 2) ? 16'h0000 : (m == 1) ? ~a : (k[0] ? (a ^ 16'h0F0F) : a);
                @(negedge i_clk_sys);
                check("rise", 32'(a), 32'(drive.rise));
                check("fall", 32'(f), 32'(drive.fall));
            end
        end
    endtask

    task automatic t_shuffle;
        wr(ADDR_SHUFFLE, 8'h04);
        check("shuf_en", 32'h1, 32'(shuf_en));
        s_a = 16'hFFFF;
        hb_en = 1'b0;
        @(negedge i_clk_sys);
        check("shuf_rise", 32'hFFFF, 32'(drive.rise));
        check("shuf_fall", 32'hFFFF, 32'(drive.fall));
        wr(ADDR_SHUFFLE, 8'hFB);
        check("shuf_off", 32'h0, 32'(shuf_en));
        check("sel_off", 32'h0, 32'(shuf_sel));
    endtask

    // ----------------------------------------------------------------
    // Sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        repeat (10) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (5) @(negedge i_clk_sys);
        t_reset();
        t_rw();
        t_trims();
        t_modes();
        t_shuffle();
        results();
    end
endmodule
`default_nettype wire
